// File: design/aic_consts.vh
`ifndef AIC_CONSTS_VH
`define AIC_CONSTS_VH
// Functional notes
// - result code is input times 1024 over reference; 0x000 ground, 0x3ff top
// - finished result lands in the data byte pair when the complete flag sets, unless a low byte read froze the pair
// - channel code 1000 powers the temperature sensor and routes it to the input
// - reference 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V
// - channel and reference changes wait until the running conversion completes
// - channel 0-7 external inputs, 8 temperature, 14 bandgap, 15 ground
// - left adjust bit chooses left or right adjusted data byte pair
// - left adjust change alters the data byte pair at once
// - enable bit one turns the converter on, zero turns it off
// - clearing enable mid conversion aborts it: no result, no flag
// - after a low byte read the data pair is frozen until the high byte read
// - left adjusted: high byte holds bits 9..2, low byte top holds bits 1..0
// - start bit reads one while converting; writing zero does nothing
// - complete flag sets on every finish, even while the data pair is frozen; writing one clears it

`define AIC_ADDR_W 12
`define AIC_IDX_RESULT_LOW 8'h78
`define AIC_IDX_RESULT_HIGH 8'h79
`define AIC_IDX_CTRL_STATUS 8'h7a
`define AIC_IDX_SELECT 8'h7c
`define AIC_IDX_IRQ_STATUS 8'h80
`define AIC_IDX_IRQ_MASK 8'h81

`define AIC_CS_ENABLE 7
`define AIC_CS_START 6
`define AIC_CS_AUTO 5
`define AIC_CS_FLAG 4
`define AIC_CS_IRQ_EN 3
`define AIC_SEL_LEFT 5

`define AIC_RESET_CTRL 8'h00
`define AIC_RESET_SELECT 8'h00
`define AIC_RESET_RESULT 10'h000
`define AIC_RESET_IRQ 2'h0

`define AIC_REF_EXTERNAL 2'h0
`define AIC_REF_SUPPLY 2'h1
`define AIC_REF_INTERNAL 2'h3
`define AIC_CHAN_EXT_MAX 4'h7
`define AIC_CHAN_TEMP 4'h8
`define AIC_CHAN_BANDGAP 4'he
`define AIC_CHAN_GROUND 4'hf

`define AIC_RESULT_MSB_CODE 10'h200
`define AIC_RESP_OKAY 2'h0
`define AIC_RESP_SLVERR 2'h2
`define AIC_IRQ_DONE 0
`define AIC_IRQ_ABORT 1

`endif

// File: design/aic_prescaler.v
`timescale 1ns/1ps
`include "aic_consts.vh"

module aic_prescaler (
  input wire aclk,
  input wire aresetn,
  input wire restart,
  input wire [2:0] divider_select,
  output reg tick
);

  reg [6:0] count;

  // cycles per converter clock, minus one
  function [6:0] div_limit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_limit = 7'h01;
        3'h1: div_limit = 7'h01;
        3'h2: div_limit = 7'h03;
        3'h3: div_limit = 7'h07;
        3'h4: div_limit = 7'h0f;
        3'h5: div_limit = 7'h1f;
        3'h6: div_limit = 7'h3f;
        default: div_limit = 7'h7f;
      endcase
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn || restart) begin
      count <= 7'h00;
      tick <= 1'b0;
    end else if (count >= div_limit(divider_select)) begin
      count <= 7'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule

// File: design/aic_sar.v
`timescale 1ns/1ps
`include "aic_consts.vh"

module aic_sar (
  input wire aclk,
  input wire aresetn,
  input wire run_enable,
  input wire start,
  input wire tick,
  input wire compare_high,
  output reg busy,
  output reg done,
  output reg sample_hold,
  output reg [9:0] trial_code,
  output reg [9:0] result
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_SETTLE = 2'h2;
  localparam ST_JUDGE = 2'h3;

  reg [1:0] state;
  reg [3:0] bit_index;
  reg [9:0] judged;

  // drop the trial bit when the input sits below the trial level
  always @* begin
    judged = trial_code;
    if (!compare_high) begin
      judged[bit_index] = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || !run_enable) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      sample_hold <= 1'b0;
      bit_index <= 4'h0;
      trial_code <= 10'h000;
      if (!aresetn) begin
        result <= `AIC_RESET_RESULT;
      end
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_SAMPLE;
            busy <= 1'b1;
            sample_hold <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            state <= ST_SETTLE;
            sample_hold <= 1'b0;
            bit_index <= 4'h9;
            trial_code <= `AIC_RESULT_MSB_CODE;
          end
        end
        ST_SETTLE: begin
          if (tick) begin
            state <= ST_JUDGE;
          end
        end
        default: begin
          if (tick) begin
            if (bit_index == 4'h0) begin
              result <= judged;
              done <= 1'b1;
              busy <= 1'b0;
              state <= ST_IDLE;
            end else begin
              trial_code <= judged | (10'h001 << (bit_index - 4'h1));
              bit_index <= bit_index - 4'h1;
              state <= ST_SETTLE;
            end
          end
        end
      endcase
    end
  end

endmodule

// File: design/aic_top.v
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "aic_consts.vh"

module aic_top (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq,
  input wire compare_high,
  output wire [9:0] trial_code,
  output wire sample_hold,
  output reg converter_power,
  output reg [3:0] channel_select_out,
  output reg [7:0] input_enable,
  output reg temp_sensor_enable,
  output reg bandgap_select,
  output reg ground_select,
  output reg ref_external_select,
  output reg ref_supply_select,
  output reg ref_internal_enable
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  reg conv_enable;
  reg auto_trigger_enable;
  reg conversion_complete_flag;
  reg conversion_complete_irq_enable;
  reg [2:0] clock_divider_select;
  reg [1:0] reference_select;
  reg left_adjust;
  reg [3:0] channel_select;
  reg [9:0] data_result;
  reg low_read_lock;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;

  reg aw_held;
  reg [11:0] aw_addr_q;
  reg w_held;
  reg [7:0] w_data_q;
  reg w_lane0_q;

  reg cmp_meta;
  reg cmp_sync;

  wire sar_busy;
  wire sar_done;
  wire [9:0] sar_result;
  wire adc_tick;

  localparam [7:0] reset_ctrl = `AIC_RESET_CTRL;
  localparam [7:0] reset_select = `AIC_RESET_SELECT;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function is_reg;
    input [11:0] addr;
    input [7:0] idx;
    begin
      is_reg = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == idx);
    end
  endfunction

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = is_reg(addr, `AIC_IDX_RESULT_LOW) ||
        is_reg(addr, `AIC_IDX_RESULT_HIGH) ||
        is_reg(addr, `AIC_IDX_CTRL_STATUS) ||
        is_reg(addr, `AIC_IDX_SELECT) ||
        is_reg(addr, `AIC_IDX_IRQ_STATUS) ||
        is_reg(addr, `AIC_IDX_IRQ_MASK);
    end
  endfunction

  // byte view of the held result under the live adjust setting
  function [7:0] result_byte;
    input [9:0] r;
    input left;
    input high;
    begin
      if (left) begin
        result_byte = high ? r[9:2] : {r[1:0], 6'h00};
      end else begin
        result_byte = high ? {6'h00, r[9:8]} : r[7:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes

  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_lane = wr_fire && w_lane0_q;

  wire wr_ctrl = wr_lane && is_reg(aw_addr_q, `AIC_IDX_CTRL_STATUS);
  wire wr_select = wr_lane && is_reg(aw_addr_q, `AIC_IDX_SELECT);
  wire wr_mask = wr_lane && is_reg(aw_addr_q, `AIC_IDX_IRQ_MASK);

  wire rd_low = rd_fire && is_reg(s_axi_araddr, `AIC_IDX_RESULT_LOW);
  wire rd_high = rd_fire && is_reg(s_axi_araddr, `AIC_IDX_RESULT_HIGH);
  wire rd_status = rd_fire && is_reg(s_axi_araddr, `AIC_IDX_IRQ_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AIC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_q) ? `AIC_RESP_OKAY : `AIC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  reg [7:0] rd_value;

  always @* begin
    rd_value = 8'h00;
    if (is_reg(s_axi_araddr, `AIC_IDX_RESULT_LOW)) begin
      rd_value = result_byte(data_result, left_adjust, 1'b0);
    end else if (is_reg(s_axi_araddr, `AIC_IDX_RESULT_HIGH)) begin
      rd_value = result_byte(data_result, left_adjust, 1'b1);
    end else if (is_reg(s_axi_araddr, `AIC_IDX_CTRL_STATUS)) begin
      // start bit stays up until the flag shows, so a poll never sees a gap
      rd_value = {conv_enable, sar_busy || sar_done, auto_trigger_enable,
        conversion_complete_flag, conversion_complete_irq_enable, clock_divider_select};
    end else if (is_reg(s_axi_araddr, `AIC_IDX_SELECT)) begin
      rd_value = {reference_select, left_adjust, 1'b0, channel_select};
    end else if (is_reg(s_axi_araddr, `AIC_IDX_IRQ_STATUS)) begin
      rd_value = {6'h00, irq_status};
    end else if (is_reg(s_axi_araddr, `AIC_IDX_IRQ_MASK)) begin
      rd_value = {6'h00, irq_mask};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AIC_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_value};
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `AIC_RESP_OKAY : `AIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and status

  wire next_enable = wr_ctrl ? w_data_q[`AIC_CS_ENABLE] : conv_enable;
  wire abort_event = sar_busy && !next_enable;
  // free running restarts right after each completion
  wire start_req = next_enable &&
    ((wr_ctrl && w_data_q[`AIC_CS_START]) || (sar_done && auto_trigger_enable));

  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_enable <= reset_ctrl[`AIC_CS_ENABLE];
      auto_trigger_enable <= 1'b0;
      conversion_complete_irq_enable <= 1'b0;
      clock_divider_select <= 3'h0;
      conversion_complete_flag <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      conv_enable <= next_enable;
      converter_power <= next_enable;
      if (wr_ctrl) begin
        auto_trigger_enable <= w_data_q[`AIC_CS_AUTO];
        conversion_complete_irq_enable <= w_data_q[`AIC_CS_IRQ_EN];
        clock_divider_select <= w_data_q[2:0];
      end
      if (sar_done) begin
        conversion_complete_flag <= 1'b1;
      end else if (wr_ctrl && w_data_q[`AIC_CS_FLAG]) begin
        conversion_complete_flag <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      reference_select <= reset_select[7:6];
      left_adjust <= 1'b0;
      channel_select <= 4'h0;
    end else if (wr_select) begin
      reference_select <= w_data_q[7:6];
      left_adjust <= w_data_q[`AIC_SEL_LEFT];
      channel_select <= w_data_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result capture and read pairing

  always @(posedge aclk) begin
    if (!aresetn) begin
      data_result <= `AIC_RESET_RESULT;
      low_read_lock <= 1'b0;
    end else begin
      if (sar_done && !low_read_lock) begin
        data_result <= sar_result;
      end
      if (rd_high) begin
        low_read_lock <= 1'b0;
      end else if (rd_low) begin
        low_read_lock <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `AIC_RESET_IRQ;
      irq_mask <= `AIC_RESET_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status[`AIC_IRQ_DONE] <= sar_done || (irq_status[`AIC_IRQ_DONE] && !rd_status);
      irq_status[`AIC_IRQ_ABORT] <= abort_event || (irq_status[`AIC_IRQ_ABORT] && !rd_status);
      if (wr_mask) begin
        irq_mask <= w_data_q[1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog selection, buffered between conversions

  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_select_out <= 4'h0;
      input_enable <= 8'h00;
      temp_sensor_enable <= 1'b0;
      bandgap_select <= 1'b0;
      ground_select <= 1'b0;
      ref_external_select <= 1'b0;
      ref_supply_select <= 1'b0;
      ref_internal_enable <= 1'b0;
    end else if (!sar_busy) begin
      channel_select_out <= channel_select;
      input_enable <= (channel_select <= `AIC_CHAN_EXT_MAX) ?
        (8'h01 << channel_select[2:0]) : 8'h00;
      temp_sensor_enable <= channel_select == `AIC_CHAN_TEMP;
      bandgap_select <= channel_select == `AIC_CHAN_BANDGAP;
      ground_select <= channel_select == `AIC_CHAN_GROUND;
      // reserved codes leave every source open and still convert
      ref_external_select <= reference_select == `AIC_REF_EXTERNAL;
      ref_supply_select <= reference_select == `AIC_REF_SUPPLY;
      ref_internal_enable <= reference_select == `AIC_REF_INTERNAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator pin and conversion engine

  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= compare_high;
      cmp_sync <= cmp_meta;
    end
  end

  aic_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(start_req && !sar_busy),
    .divider_select(clock_divider_select),
    .tick(adc_tick)
  );

  aic_sar u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .run_enable(next_enable),
    .start(start_req),
    .tick(adc_tick),
    .compare_high(cmp_sync),
    .busy(sar_busy),
    .done(sar_done),
    .sample_hold(sample_hold),
    .trial_code(trial_code),
    .result(sar_result)
  );

endmodule

// File: verification/aic_analog_model.sv
`timescale 1ns/1ps
module aic_analog_model (
  input wire logic converter_power,
  input wire logic [9:0] trial_code,
  input wire logic [9:0] vin,
  output logic compare_high
);
  // comparator: high keeps the trial bit
  always @* begin
    if (converter_power)
      compare_high = (vin >= trial_code);
    else
      compare_high = ~trial_code[0];
  end
endmodule

// File: verification/aic_top_properties.sv
`timescale 1ns/1ps
module aic_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sample_hold,
  input wire logic converter_power,
  input wire logic [3:0] channel_select_out,
  input wire logic [7:0] input_enable,
  input wire logic temp_sensor_enable,
  input wire logic bandgap_select,
  input wire logic ground_select,
  input wire logic ref_external_select,
  input wire logic ref_supply_select,
  input wire logic ref_internal_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_in_onehot;
    $onehot0(input_enable);
  endproperty
  a_in_onehot: assert property (p_in_onehot) else $error("input enable not one-hot");
  property p_in_match;
    |input_enable |-> !channel_select_out[3] &&
      input_enable == (8'h01 << channel_select_out[2:0]);
  endproperty
  a_in_match: assert property (p_in_match) else $error("input enable vs channel");
  property p_temp;
    temp_sensor_enable == (channel_select_out == 4'h8);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature sensor decode");
  property p_special;
    bandgap_select == (channel_select_out == 4'he) && ground_select == (channel_select_out == 4'hf);
  endproperty
  a_special: assert property (p_special) else $error("bandgap or ground decode");
  property p_ref;
    $onehot0({ref_external_select, ref_supply_select, ref_internal_enable});
  endproperty
  a_ref: assert property (p_ref) else $error("reference decode overlap");
  property p_lock;
    sample_hold && $past(sample_hold) |-> $stable(channel_select_out) && $stable(ref_internal_enable);
  endproperty
  a_lock: assert property (p_lock) else $error("selection moved while sampling");
  property p_off;
    !converter_power && !$past(converter_power) |-> !sample_hold;
  endproperty
  a_off: assert property (p_off) else $error("sampling while powered off");
  property p_b;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b: assert property (p_b) else $error("write response dropped");
  property p_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w: assert property (p_w) else $error("write response late");
  property p_r;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r: assert property (p_r) else $error("read data late");
endmodule
bind aic_top aic_top_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .sample_hold(sample_hold), .converter_power(converter_power),
  .channel_select_out(channel_select_out), .input_enable(input_enable),
  .temp_sensor_enable(temp_sensor_enable), .bandgap_select(bandgap_select),
  .ground_select(ground_select), .ref_external_select(ref_external_select),
  .ref_supply_select(ref_supply_select), .ref_internal_enable(ref_internal_enable));

// File: verification/tb_adc_input_result_control.sv
`timescale 1ns/1ps
module tb_adc_input_result_control;
  localparam logic [11:0] A_LO = 12'h1e0;
  localparam logic [11:0] A_HI = 12'h1e4;
  localparam logic [11:0] A_CS = 12'h1e8;
  localparam logic [11:0] A_SEL = 12'h1f0;
  localparam logic [11:0] A_IST = 12'h200;
  localparam logic [11:0] A_IMS = 12'h204;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0] trial_code, vin = 10'h0;
  logic compare_high, sample_hold, converter_power, temp_sensor_enable, bandgap_select;
  logic ground_select, ref_external_select, ref_supply_select, ref_internal_enable;
  logic [3:0] channel_select_out;
  logic [7:0] input_enable;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 aclk = ~aclk;
  aic_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .compare_high(compare_high), .trial_code(trial_code),
    .sample_hold(sample_hold), .converter_power(converter_power),
    .channel_select_out(channel_select_out), .input_enable(input_enable),
    .temp_sensor_enable(temp_sensor_enable), .bandgap_select(bandgap_select),
    .ground_select(ground_select), .ref_external_select(ref_external_select),
    .ref_supply_select(ref_supply_select), .ref_internal_enable(ref_internal_enable));
  aic_analog_model u_far (.converter_power(converter_power), .trial_code(trial_code),
    .vin(vin), .compare_high(compare_high));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string nm);
    rdw(a);
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic wait_done();
    do rdw(A_CS); while (rd[6] === 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(A_CS, 8'h00, "ctrl");
    rdchk(A_SEL, 8'h00, "select");
    rdchk(A_LO, 8'h00, "low");
    rdchk(A_HI, 8'h00, "high");
    rdw(12'h1ec);
    chk("bad read resp", 32'h2, {30'h0, rs});
    wr(12'h3fc, 8'hff);
    chk("bad write resp", 32'h2, {30'h0, rs});
  endtask
  task automatic t_decode();
    for (int i = 0; i < 16; i++) begin
      wr(A_SEL, {4'h4, i[3:0]});
      repeat (2) @(posedge aclk);
      chk("inputs", (i < 8) ? (32'h1 << i) : 32'h0, {24'h0, input_enable});
      chk("temp", {31'h0, i == 8}, {31'h0, temp_sensor_enable});
      chk("special", {30'h0, i == 14, i == 15}, {30'h0, bandgap_select, ground_select});
    end
    for (int r = 0; r < 4; r++) begin
      wr(A_SEL, {r[1:0], 6'h0});
      repeat (2) @(posedge aclk);
      chk("ref", {29'h0, r == 0, r == 1, r == 3},
        {29'h0, ref_external_select, ref_supply_select, ref_internal_enable});
    end
  endtask
  task automatic t_conv();
    vin <= 10'h2a5;
    wr(A_IMS, 8'h03);
    wr(A_SEL, 8'h43);
    wr(A_CS, 8'hc3);
    wr(A_CS, 8'h83);
    rdw(A_CS);
    chk("busy", 32'h1, {31'h0, rd[6]});
    wait_done();
    chk("flag", 32'h1, {31'h0, rd[4]});
    chk("irq", 32'h1, {31'h0, irq});
    rdchk(A_LO, 8'ha5, "low");
    rdchk(A_HI, 8'h02, "high");
    rdchk(A_IST, 8'h01, "irq status");
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(A_CS, 8'h93);
    rdchk(A_CS, 8'h83, "flag clear");
    wr(A_SEL, 8'h63);
    rdchk(A_HI, 8'ha9, "left high");
    rdchk(A_LO, 8'h40, "left low");
  endtask
  task automatic t_lock();
    wr(A_SEL, 8'h4a);
    rdchk(A_LO, 8'ha5, "low");
    vin <= 10'h155;
    wr(A_CS, 8'hc3);
    wait_done();
    chk("locked flag", 32'h1, {31'h0, rd[4]});
    rdchk(A_HI, 8'h02, "held high");
    wr(A_CS, 8'hd3);
    wait_done();
    rdchk(A_LO, 8'h55, "reserved low");
    rdchk(A_HI, 8'h01, "reserved high");
  endtask
  task automatic t_abort();
    rdw(A_IST);
    wr(A_IMS, 8'h01);
    wr(A_SEL, 8'hc3);
    vin <= 10'h3ff;
    wr(A_CS, 8'hd3);
    // rewrite the selection inside the sampling phase
    wr(A_SEL, 8'hc8);
    repeat (4) @(posedge aclk);
    chk("held channel", 32'h3, {28'h0, channel_select_out});
    wr(A_CS, 8'h03);
    repeat (3) @(posedge aclk);
    chk("power", 32'h0, {31'h0, converter_power});
    chk("masked irq", 32'h0, {31'h0, irq});
    // long enough for an unaborted conversion to land
    repeat (200) @(posedge aclk);
    rdchk(A_CS, 8'h03, "aborted ctrl");
    rdchk(A_LO, 8'h55, "aborted low");
    rdchk(A_IST, 8'h02, "abort status");
    chk("new channel", 32'h8, {28'h0, channel_select_out});
    chk("temp path", 32'h3, {30'h0, temp_sensor_enable, ref_internal_enable});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_decode();
    t_conv();
    t_lock();
    t_abort();
    print_verdict();
  end
endmodule
